// File: design/sdd_defs.svh
// Purpose: shared constants of the stereo decimator core
// Assumes: one master clock at 20 MHz
// Notes: counts derive from the times they stand for
`ifndef SDD_DEFS_SVH
`define SDD_DEFS_SVH

// clocking
`define CLK_PERIOD_NS 50
`define DIV_384 3'h6
`define DIV_256 3'h4
`define OSR 64
`define SLOT_W 6

// filter
`define CIC_ORDER 4
`define ACC_W 26
`define WORD_W 16
`define OUT_SHIFT 9
`define GROUP_DELAY_WORDS 36
`define CIC_DELAY_SAMPLES 126
`define PIPE_LEN (`GROUP_DELAY_WORDS * `OSR - `CIC_DELAY_SAMPLES)
`define PIPE_RESET 2'h2
`define POS_FULL 16'h7FFF
`define NEG_FULL 16'h8000

// modulator recovery, longest time rounded down
`define MOD_RST_TIME_NS 5000
`define MOD_RST_CYCLES (`MOD_RST_TIME_NS / `CLK_PERIOD_NS)
`define MOD_RST_W 8

// output buffer
`define FIFO_DEPTH 8
`define FRAME_BITS 64

`endif

// File: design/sdd_pkg.sv
// Purpose: types of the stereo decimator core
// Assumes: constants come from sdd_defs.svh
// Notes: none
`include "sdd_defs.svh"
package sdd_pkg;
	typedef logic signed [`ACC_W-1:0] acc_t;
	typedef logic [`WORD_W-1:0] word_t;
	typedef struct packed {
		word_t left;
		word_t right;
	} stereo_s;
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_WAIT_FALL = 2'b01,
		SER_WAIT_RISE = 2'b10,
		SER_RUN = 2'b11
	} ser_state_e;
endpackage

// File: design/clk_divider.sv
// Purpose: master clock divider and frame slot counter
// Assumes: ratio select already synchronised
// Notes: tick marks the last master cycle of a modulator period
`include "sdd_defs.svh"
module clk_divider (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic ratio_384_i,
	// timing outputs
	output logic mod_tick_o,
	output logic mod_clk_o,
	output logic [`SLOT_W-1:0] slot_o,
	output logic frame_tick_o
);
	logic [2:0] div_cnt;
	logic [2:0] next_div_cnt;
	logic [2:0] limit;
	logic next_mod_clk;
	logic [`SLOT_W-1:0] next_slot;

	always_comb begin
		limit = ratio_384_i ? (`DIV_384 - 3'h1) : (`DIV_256 - 3'h1);
		mod_tick_o = (div_cnt >= limit);
		frame_tick_o = mod_tick_o && (slot_o == {`SLOT_W{1'b1}});
		next_div_cnt = mod_tick_o ? 3'h0 : div_cnt + 3'h1;
		next_slot = mod_tick_o ? slot_o + `SLOT_W'(1) : slot_o;
		next_mod_clk = (next_div_cnt < {1'b0, limit[2:1]} + 3'h1);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			div_cnt <= 3'h0;
			slot_o <= '0;
			mod_clk_o <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			slot_o <= next_slot;
			mod_clk_o <= next_mod_clk;
		end
	end
endmodule

// File: design/sync_fifo.sv
// Purpose: small synchronous word buffer
// Assumes: depth is a power of two
// Notes: read data is the flop at the read pointer
module sync_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic [AW:0] next_wr_ptr;
	logic [AW:0] next_rd_ptr;
	logic push;
	logic pop;

	always_comb begin
		in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
		out_valid_o = (wr_ptr != rd_ptr);
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		next_wr_ptr = push ? wr_ptr + (AW+1)'(1) : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
		out_data_o = mem[rd_ptr[AW-1:0]];
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end
endmodule

// File: design/sd_decimator_top.sv
// Purpose: stereo one-bit decimator with clocking and serial output
// Assumes: modulator bits arrive on the master clock domain
// Notes: configuration, overload and serial clock pins pass two flip-flops first
`include "sdd_defs.svh"
module sd_decimator_top #(
	parameter int PIPE_LEN = `PIPE_LEN,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	// configuration pins
	input wire logic CLK_RATIO_384_I,
	input wire logic MASTER_MODE_I,
	// modulator side
	input wire logic [1:0] BITSTREAM_I,
	input wire logic [1:0] OVERLOAD_I,
	output logic MOD_CLK_O,
	output logic MOD_RESET_O,
	// serial clocks, two-way
	input wire logic BCLK_I,
	output logic BCLK_O,
	output logic BCLK_OE_N_O,
	input wire logic LRCK_I,
	output logic LRCK_O,
	output logic LRCK_OE_N_O,
	// serial data
	output logic SERIAL_SAMPLE_OUTPUT_O
);
	import sdd_pkg::*;

	function automatic word_t sat16(input acc_t v);
		acc_t s;
		s = v >>> `OUT_SHIFT;
		if (s > acc_t'($signed(`POS_FULL))) begin
			sat16 = `POS_FULL;
		end else if (s < -acc_t'(32768)) begin
			sat16 = `NEG_FULL;
		end else begin
			sat16 = s[`WORD_W-1:0];
		end
	endfunction

	// frame layout: left, pad, right, pad
	function automatic logic [`FRAME_BITS-1:0] frame_of(input stereo_s p);
		frame_of = {p.left, 16'h0000, p.right, 16'h0000};
	endfunction

	// pin synchronisers
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic [1:0] edge_prev;
	logic ratio_384;
	logic master;
	logic [1:0] ovl;
	logic bclk_fall;
	logic lrck_rise;
	logic lrck_fall;

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
			edge_prev <= 2'h0;
		end else begin
			sync1 <= {LRCK_I, BCLK_I, OVERLOAD_I, MASTER_MODE_I, CLK_RATIO_384_I};
			sync2 <= sync1;
			edge_prev <= sync2[5:4];
		end
	end

	always_comb begin
		ratio_384 = sync2[0];
		master = sync2[1];
		ovl = sync2[3:2];
		bclk_fall = edge_prev[0] && !sync2[4];
		lrck_rise = !edge_prev[1] && sync2[5];
		lrck_fall = edge_prev[1] && !sync2[5];
	end

	// clock chain
	logic mod_tick;
	logic mod_clk;
	logic [`SLOT_W-1:0] slot;
	logic frame_tick;

	clk_divider u_div (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.ratio_384_i(ratio_384),
		.mod_tick_o(mod_tick),
		.mod_clk_o(mod_clk),
		.slot_o(slot),
		.frame_tick_o(frame_tick)
	);

	// modulator recovery
	logic [`MOD_RST_W-1:0] mrst_cnt;
	logic [`MOD_RST_W-1:0] next_mrst_cnt;

	always_comb begin
		if (|ovl) begin
			next_mrst_cnt = `MOD_RST_W'(`MOD_RST_CYCLES);
		end else if (mrst_cnt != '0) begin
			next_mrst_cnt = mrst_cnt - `MOD_RST_W'(1);
		end else begin
			next_mrst_cnt = mrst_cnt;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			mrst_cnt <= '0;
			MOD_RESET_O <= 1'b0;
			MOD_CLK_O <= 1'b0;
		end else begin
			mrst_cnt <= next_mrst_cnt;
			MOD_RESET_O <= (next_mrst_cnt != '0);
			MOD_CLK_O <= mod_clk;
		end
	end

	// decimation filter
	logic [PIPE_LEN-1:0] pipe [2];
	logic [PIPE_LEN-1:0] next_pipe [2];
	acc_t integ [2][`CIC_ORDER];
	acc_t next_integ [2][`CIC_ORDER];
	acc_t dly [2][`CIC_ORDER];
	acc_t next_dly [2][`CIC_ORDER];
	acc_t comb_val;
	acc_t in_val;
	stereo_s dec_word;
	stereo_s next_dec_word;
	logic dec_valid;
	logic next_dec_valid;
	logic fifo_in_ready;
	logic push;
	word_t w [2];

	always_comb begin
		next_pipe = pipe;
		next_integ = integ;
		next_dly = dly;
		next_dec_word = dec_word;
		comb_val = '0;
		in_val = '0;
		w[0] = dec_word.left;
		w[1] = dec_word.right;
		push = dec_valid && fifo_in_ready;
		next_dec_valid = dec_valid && !push;
		for (int ch = 0; ch < 2; ch++) begin
			if (mod_tick) begin
				next_pipe[ch] = {pipe[ch][PIPE_LEN-2:0], BITSTREAM_I[ch]};
				in_val = pipe[ch][PIPE_LEN-1] ? acc_t'(1) : -acc_t'(1);
				next_integ[ch][0] = integ[ch][0] + in_val;
				for (int k = 1; k < `CIC_ORDER; k++) begin
					next_integ[ch][k] = integ[ch][k] + integ[ch][k-1];
				end
			end
			if (frame_tick) begin
				comb_val = integ[ch][`CIC_ORDER-1];
				for (int k = 0; k < `CIC_ORDER; k++) begin
					next_dly[ch][k] = comb_val;
					comb_val = comb_val - dly[ch][k];
				end
				if (mrst_cnt != '0) begin
					w[ch] = comb_val[`ACC_W-1] ? `NEG_FULL : `POS_FULL;
				end else begin
					w[ch] = sat16(comb_val);
				end
			end
		end
		if (frame_tick) begin
			next_dec_word.left = w[0];
			next_dec_word.right = w[1];
			next_dec_valid = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			for (int ch = 0; ch < 2; ch++) begin
				pipe[ch] <= {(PIPE_LEN/2){`PIPE_RESET}};
				for (int k = 0; k < `CIC_ORDER; k++) begin
					integ[ch][k] <= '0;
					dly[ch][k] <= '0;
				end
			end
			dec_word <= '0;
			dec_valid <= 1'b0;
		end else begin
			pipe <= next_pipe;
			integ <= next_integ;
			dly <= next_dly;
			dec_word <= next_dec_word;
			dec_valid <= next_dec_valid;
		end
	end

	// output buffer
	logic fifo_out_valid;
	logic fifo_out_ready;
	stereo_s fifo_out;

	sync_fifo #(
		.WIDTH($bits(stereo_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.in_valid_i(dec_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(dec_word),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out)
	);

	// serial interface
	ser_state_e state;
	ser_state_e next_state;
	logic [`FRAME_BITS-1:0] shreg;
	logic [`FRAME_BITS-1:0] next_shreg;
	logic next_serial_sample_output;
	logic next_lrck;
	logic next_bclk;
	logic frame_start;
	logic bit_strobe;

	always_comb begin
		frame_start = master ? frame_tick : lrck_rise;
		bit_strobe = master ? mod_tick : bclk_fall;
		next_state = state;
		next_shreg = shreg;
		fifo_out_ready = 1'b0;
		case (state)
			SER_IDLE: begin
				next_state = master ? SER_RUN : SER_WAIT_FALL;
			end
			SER_WAIT_FALL: begin
				if (master) begin
					next_state = SER_IDLE;
				end else if (lrck_fall) begin
					next_state = SER_WAIT_RISE;
				end
			end
			SER_WAIT_RISE: begin
				if (master) begin
					next_state = SER_IDLE;
				end else if (lrck_rise) begin
					next_state = SER_RUN;
				end
			end
			SER_RUN: begin
				if (frame_start) begin
					fifo_out_ready = 1'b1;
					if (fifo_out_valid) begin
						next_shreg = frame_of(fifo_out);
					end else begin
						next_shreg = '0;
					end
				end else if (bit_strobe) begin
					next_shreg = {shreg[`FRAME_BITS-2:0], 1'b0};
				end
			end
			default: begin
				next_state = SER_IDLE;
			end
		endcase
		if (state == SER_WAIT_RISE && lrck_rise) begin
			fifo_out_ready = 1'b1;
			next_shreg = fifo_out_valid ? frame_of(fifo_out) : '0;
		end
		next_serial_sample_output = next_shreg[`FRAME_BITS-1];
		next_lrck = master && !slot[`SLOT_W-1];
		next_bclk = master && mod_clk;
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			state <= SER_IDLE;
			shreg <= '0;
			SERIAL_SAMPLE_OUTPUT_O <= 1'b0;
			LRCK_O <= 1'b0;
			BCLK_O <= 1'b0;
			LRCK_OE_N_O <= 1'b1;
			BCLK_OE_N_O <= 1'b1;
		end else begin
			state <= next_state;
			shreg <= next_shreg;
			SERIAL_SAMPLE_OUTPUT_O <= next_serial_sample_output;
			LRCK_O <= next_lrck;
			BCLK_O <= next_bclk;
			LRCK_OE_N_O <= !master;
			BCLK_OE_N_O <= !master;
		end
	end
endmodule

// File: dv/sd_decimator_props.sv
// Purpose: port checker for the decimator core
// Assumes: ratio and mode pins change only under reset
// Notes: bound to the top module below
module sd_decimator_props (
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	// pins watched
	input wire logic CLK_RATIO_384_I,
	input wire logic MASTER_MODE_I,
	input wire logic [1:0] OVERLOAD_I,
	input wire logic MOD_CLK_O,
	input wire logic MOD_RESET_O,
	input wire logic BCLK_O,
	input wire logic BCLK_OE_N_O,
	input wire logic LRCK_O,
	input wire logic LRCK_OE_N_O,
	input wire logic SERIAL_SAMPLE_OUTPUT_O
);
	logic lr_d;
	logic armed;
	logic [7:0] half_cnt;
	// cycles since the last frame clock edge
	// armed from the first fall, the half before it may be short
	always_ff @(posedge CLK_SYS_I) begin
		lr_d <= LRCK_O;
		armed <= RST_N_I && !BCLK_OE_N_O && (armed || (lr_d && !LRCK_O));
		half_cnt <= (LRCK_O != lr_d) ? 8'h01 : half_cnt + 8'h01;
	end
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	div_four_a: assert property (
		!CLK_RATIO_384_I [*8] ##0 $rose(MOD_CLK_O) |-> ##4 $rose(MOD_CLK_O)) else $error("mod clock not over 4");
	div_six_a: assert property (
		CLK_RATIO_384_I [*8] ##0 $rose(MOD_CLK_O) |-> ##6 $rose(MOD_CLK_O)) else $error("mod clock not over 6");
	reset_clear_a: assert property (disable iff (1'b0)
		!RST_N_I |=> !MOD_RESET_O && !SERIAL_SAMPLE_OUTPUT_O && !LRCK_O && BCLK_OE_N_O && LRCK_OE_N_O)
		else $error("outputs not cleared in reset");
	master_drive_a: assert property (
		MASTER_MODE_I [*5] |-> !BCLK_OE_N_O && !LRCK_OE_N_O) else $error("master clocks not driven");
	slave_quiet_a: assert property (
		!MASTER_MODE_I [*5] |-> BCLK_OE_N_O && LRCK_OE_N_O && !LRCK_O) else $error("slave clocks driven");
	bit_clock_a: assert property (
		!BCLK_OE_N_O && $past(!BCLK_OE_N_O) |-> BCLK_O == MOD_CLK_O) else $error("bit clock off mod clock");
	ovl_start_a: assert property (
		OVERLOAD_I != 2'h0 |-> ##[1:4] MOD_RESET_O) else $error("mod reset late");
	ovl_end_a: assert property (
		OVERLOAD_I == 2'h0 && $past(OVERLOAD_I) != 2'h0 |-> (MOD_RESET_O throughout ##95 1) ##[1:10] !MOD_RESET_O)
		else $error("mod reset length wrong");
	frame_half_a: assert property (
		armed && LRCK_O != lr_d |-> half_cnt == (CLK_RATIO_384_I ? 8'hC0 : 8'h80)) else $error("half frame length");
endmodule
bind sd_decimator_top sd_decimator_props i_sd_decimator_props (.CLK_SYS_I, .RST_N_I, .CLK_RATIO_384_I,
	.MASTER_MODE_I, .OVERLOAD_I, .MOD_CLK_O, .MOD_RESET_O, .BCLK_O, .BCLK_OE_N_O, .LRCK_O, .LRCK_OE_N_O,
	.SERIAL_SAMPLE_OUTPUT_O);

// File: dv/serial_rx_model.sv
// Purpose: serial receiver on the far side of the data output
// Assumes: samples data on bit clock rise, left while frame clock high
// Notes: flags a pair once the right word is in
module serial_rx_model (
	// clock
	input wire logic clk_i,
	// serial wires
	input wire logic bclk_i,
	input wire logic lrck_i,
	input wire logic data_i,
	// captured pair
	output sdd_pkg::stereo_s pair_o,
	output logic pair_valid_o
);
	import sdd_pkg::*;
	logic bclk_d = 1'b0;
	logic lr_last = 1'b0;
	logic [5:0] idx = 6'h0;
	logic [5:0] n_idx;
	word_t sr = 16'h0000;
	assign n_idx = (lrck_i != lr_last) ? 6'h01 : idx + 6'h01;
	always_ff @(posedge clk_i) begin
		bclk_d <= bclk_i;
		pair_valid_o <= 1'b0;
		if (bclk_i && !bclk_d) begin
			idx <= n_idx;
			lr_last <= lrck_i;
			sr <= {sr[14:0], data_i};
			if (n_idx == 6'h10 && lrck_i) pair_o.left <= {sr[14:0], data_i};
			if (n_idx == 6'h10 && !lrck_i) begin
				pair_o.right <= {sr[14:0], data_i};
				pair_valid_o <= 1'b1;
			end
		end
	end
endmodule

// File: dv/sd_decimator_top_bench.sv
// Purpose: self-checking bench of the decimator core
// Assumes: constant and alternating bit patterns settle to known words
// Notes: short delay line keeps the run brief
module sd_decimator_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import sdd_pkg::*;
	logic clk, rst_n, ratio, master, mod_d, bclk_w, lrck_w;
	logic slv_on = 1'b0, slv_bclk = 1'b0, slv_lrck = 1'b0;
	int slv_cnt = 0;
	logic mod_clk, mod_rst, bclk_o, bclk_oe_n, lrck_o, lrck_oe_n, serial_sample_output, pv;
	logic [1:0] bits, ovl, pat0, pat1;
	stereo_s pair, note;
	stereo_s notes[$];
	int n_errors = 0, samples_checked = 0, cycles = 0, n_pairs = 0, seed = 2, i;
	assign bclk_w = bclk_oe_n ? slv_bclk : bclk_o;
	assign lrck_w = lrck_oe_n ? slv_lrck : lrck_o;
	sd_decimator_top #(.PIPE_LEN(2)) i_sd_decimator_top (.CLK_SYS_I(clk), .RST_N_I(rst_n),
		.CLK_RATIO_384_I(ratio), .MASTER_MODE_I(master), .BITSTREAM_I(bits), .OVERLOAD_I(ovl),
		.MOD_CLK_O(mod_clk), .MOD_RESET_O(mod_rst), .BCLK_I(bclk_w), .BCLK_O(bclk_o), .BCLK_OE_N_O(bclk_oe_n),
		.LRCK_I(lrck_w), .LRCK_O(lrck_o), .LRCK_OE_N_O(lrck_oe_n), .SERIAL_SAMPLE_OUTPUT_O(serial_sample_output));
	serial_rx_model i_serial_rx_model (.clk_i(clk), .bclk_i(bclk_w), .lrck_i(lrck_w), .data_i(serial_sample_output),
		.pair_o(pair), .pair_valid_o(pv));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// partner clocks for slave mode, locked to the master clock
	always @(negedge clk) begin
		slv_cnt <= (slv_cnt + 1) % 384;
		slv_bclk <= slv_on && (slv_cnt % 6) >= 3;
		slv_lrck <= slv_on && slv_cnt < 192;
	end
	task automatic check(input word_t seen, input word_t exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic word_t exp_of(input logic [1:0] p);
		return (p == 2'h2) ? 16'h0000 : (p[0] ? 16'h7FFF : 16'h8000);
	endfunction
	// bit patterns per modulator period, plus timeout
	always @(negedge clk) begin
		cycles <= cycles + 1;
		mod_d <= mod_clk;
		if (mod_clk && !mod_d) begin
			bits[0] <= (pat0 == 2'h2) ? ~bits[0] : pat0[0];
			bits[1] <= (pat1 == 2'h2) ? ~bits[1] : pat1[0];
		end
		if (cycles == 90000) begin
			n_errors++;
			complete_run();
		end
	end
	// oldest note against each captured pair
	always @(negedge clk) begin
		if (pv) n_pairs++;
		if (pv && notes.size() > 0) begin
			note = notes.pop_front();
			check(pair.left, note.left);
			check(pair.right, note.right);
		end
	end
	task automatic reset_dut(input logic r, input logic m);
		rst_n = 1'b0;
		ratio = r;
		master = m;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
	endtask
	task automatic run_case(input logic [1:0] p0, input logic [1:0] p1);
		pat0 = p0;
		pat1 = p1;
		repeat (10) @(posedge pv);
		repeat (2) @(negedge clk);
		repeat (3) notes.push_back('{left: exp_of(p0), right: exp_of(p1)});
		repeat (4) @(posedge pv);
		repeat (2) @(negedge clk);
	endtask
	initial begin
		bits = 2'h0;
		ovl = 2'h0;
		pat0 = 2'h2;
		pat1 = 2'h2;
		mod_d = 1'b0;
		for (i = 0; i < 2; i++) begin
			reset_dut(i[0], 1'b1);
			run_case(2'h1, 2'h0);
			run_case(2'h2, 2'h2);
			repeat (2) run_case(2'($unsigned($random(seed)) % 3), 2'($unsigned($random(seed)) % 3));
			ovl = 2'($unsigned($random(seed)) % 3 + 1);
			repeat (40) @(negedge clk);
			run_case(2'h1, 2'h1);
			ovl = 2'h0;
			repeat (150) @(negedge clk);
		end
		reset_dut(1'b0, 1'b0);
		n_pairs = 0;
		repeat (800) @(negedge clk);
		check(word_t'(n_pairs), 16'h0000);
		slv_on = 1'b1;
		reset_dut(1'b1, 1'b0);
		run_case(2'h0, 2'h1);
		run_case(2'($unsigned($random(seed)) % 3), 2'h2);
		complete_run();
	end
endmodule
